// ==== design/dcwd_cmd_decode.sv ====
// command decoder for the five state bits of the control word
`timescale 1ns/1ps
`include "dcwd_regs.svh"
module dcwd_cmd_decode
  import dcwd_pkg::*;
(
  input  wire logic [15:0] cw,
  output dcwd_cmd_t        cmd
);

  // ---------------------------------------------------------------
  // pattern match, fault reset set means no level command
  // ---------------------------------------------------------------
  function automatic dcwd_cmd_t decode(input logic [15:0] w);
    logic so;
    logic ev;
    logic qs;
    logic eo;
    so = w[`DCWD_BIT_SWITCH_ON];
    ev = w[`DCWD_BIT_ENA_VOLT];
    qs = w[`DCWD_BIT_QSTOP];
    eo = w[`DCWD_BIT_ENA_OP];
    if (w[`DCWD_BIT_FLT_RST]) begin
      decode = DCWD_CMD_NONE;
    end else if (!ev) begin
      decode = DCWD_CMD_DISVOLT;            // [RULE_08]
    end else if (!qs) begin
      decode = DCWD_CMD_QSTOP;              // [RULE_09]
    end else if (!so) begin
      decode = DCWD_CMD_SHUTDOWN;           // [RULE_06]
    end else if (!eo) begin
      decode = DCWD_CMD_SWITCHON;           // [RULE_07]
    end else begin
      decode = DCWD_CMD_ENAOP;              // [RULE_10]
    end
  endfunction : decode

  assign cmd = decode(cw);

endmodule : dcwd_cmd_decode

// ==== design/dcwd_pkg.sv ====
// types of the drive control word decoder
package dcwd_pkg;

  // ---------------------------------------------------------------
  // operating states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    DCWD_SOD   = 6'h01,
    DCWD_RTSO  = 6'h02,
    DCWD_SWON  = 6'h04,
    DCWD_OPEN  = 6'h08,
    DCWD_QSA   = 6'h10,
    DCWD_FAULT = 6'h20
  } dcwd_state_t;

  // ---------------------------------------------------------------
  // decoded state commands
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DCWD_CMD_NONE     = 3'h0,
    DCWD_CMD_SHUTDOWN = 3'h1,
    DCWD_CMD_SWITCHON = 3'h2,
    DCWD_CMD_DISVOLT  = 3'h3,
    DCWD_CMD_QSTOP    = 3'h4,
    DCWD_CMD_ENAOP    = 3'h5
  } dcwd_cmd_t;

  // ---------------------------------------------------------------
  // control word write strobe with data
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } dcwd_wr_t;

  // ---------------------------------------------------------------
  // whole state of the decoder
  // ---------------------------------------------------------------
  typedef struct packed {
    dcwd_state_t state;
    logic [15:0] cw;
    logic        jog_s1;
    logic        jog_s2;
    logic        jog_prev;
    logic        jog_mode;
    logic        jog_run;
    logic        jog_stopping;
    logic        fault_clr;
    logic        power_en;
    logic        qstop_req;
    logic [3:0]  state_num;
  } dcwd_st_t;

endpackage : dcwd_pkg

// ==== design/dcwd_regs.svh ====
// constants for the drive control word decoder
//
// Overview of operation
// RULE_01 - jog-negative rise: power on, jog, move negative
// RULE_02 - jog-negative fall: stop motion, then power off
// RULE_03 - 16-bit control word with fixed command bits
// RULE_04 - master writes zero into bits 10..15
// RULE_05 - written control word acts immediately
// RULE_06 - shutdown pattern goes to ready-to-switch-on
// RULE_07 - switch-on pattern goes to switched-on
// RULE_08 - enable voltage low goes to switch-on-disabled
// RULE_09 - quick stop: quick-stop-active or switch-on-disabled
// RULE_10 - all four bits set enables operation
// RULE_11 - fault reset rising edge clears error
// RULE_12 - bit 8 set halts ongoing movement
// RULE_13 - bits 4..6 and 9 forwarded to mode
// RULE_14 - invalid pattern keeps present state
`ifndef DCWD_REGS_SVH
`define DCWD_REGS_SVH

// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define DCWD_CW_WIDTH      16
`define DCWD_CW_RESET      16'h0000
`define DCWD_BIT_SWITCH_ON 0
`define DCWD_BIT_ENA_VOLT  1
`define DCWD_BIT_QSTOP     2
`define DCWD_BIT_ENA_OP    3
`define DCWD_BIT_MODE_LO   4
`define DCWD_BIT_MODE_HI   6
`define DCWD_BIT_FLT_RST   7
`define DCWD_BIT_HALT      8
`define DCWD_BIT_MODE_9    9
`define DCWD_RSVD_LO       10
`define DCWD_RSVD_HI       15

// ---------------------------------------------------------------
// state numbers shown on the state-number output
// ---------------------------------------------------------------
`define DCWD_NUM_SOD       4'h3
`define DCWD_NUM_RTSO      4'h4
`define DCWD_NUM_SWON      4'h5
`define DCWD_NUM_OPEN      4'h6
`define DCWD_NUM_QSA       4'h7
`define DCWD_NUM_FAULT     4'h9

`endif

// ==== design/dcwd_top.sv ====
// drive control word decoder and operating state machine
`timescale 1ns/1ps
`include "dcwd_regs.svh"
module dcwd_top
  import dcwd_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CW_WR,
  input  wire logic [15:0] CW_WDATA,
  input  wire logic        JOG_NEG_ENA_IN,
  input  wire logic        FAULT_IN,
  input  wire logic        STANDSTILL,
  output logic      [15:0] CW_RDATA,
  output logic      [5:0]  STATE_ONEHOT,
  output logic      [3:0]  STATE_NUM,
  output logic             POWER_EN,
  output logic             QSTOP_REQ,
  output logic             HALT_REQ,
  output logic             JOG_MODE,
  output logic             JOG_NEG_RUN,
  output logic             FAULT_CLR,
  output logic      [3:0]  MODE_BITS
);

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  dcwd_st_t  st_q;
  dcwd_st_t  st_d;
  dcwd_wr_t  wr;
  dcwd_cmd_t cmd;
  logic [15:0] cw_eff;

  // ---------------------------------------------------------------
  // effective word: a write acts in its own cycle
  // ---------------------------------------------------------------
  assign wr      = {CW_WR, CW_WDATA};
  assign cw_eff  = wr.wr ? wr.data : st_q.cw;                // [RULE_05]

  dcwd_cmd_decode u_dec (
    .cw  (cw_eff),
    .cmd (cmd)
  );

  // ---------------------------------------------------------------
  // state number for a one-hot state
  // ---------------------------------------------------------------
  function automatic logic [3:0] state_number(input dcwd_state_t s);
    case (s)
      DCWD_SOD:   state_number = `DCWD_NUM_SOD;
      DCWD_RTSO:  state_number = `DCWD_NUM_RTSO;
      DCWD_SWON:  state_number = `DCWD_NUM_SWON;
      DCWD_OPEN:  state_number = `DCWD_NUM_OPEN;
      DCWD_QSA:   state_number = `DCWD_NUM_QSA;
      DCWD_FAULT: state_number = `DCWD_NUM_FAULT;
      default:    state_number = `DCWD_NUM_SOD;
    endcase
  endfunction : state_number

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic jog_rise;
  logic jog_fall;
  logic flt_rst_rise;

  always_comb begin
    st_d = st_q;
    jog_rise = st_q.jog_s2 && !st_q.jog_prev;
    jog_fall = !st_q.jog_s2 && st_q.jog_prev;
    flt_rst_rise = wr.wr && wr.data[`DCWD_BIT_FLT_RST]
                   && !st_q.cw[`DCWD_BIT_FLT_RST];             // [RULE_11]

    // pin synchroniser and edge history
    st_d.jog_s1   = JOG_NEG_ENA_IN;
    st_d.jog_s2   = st_q.jog_s1;
    st_d.jog_prev = st_q.jog_s2;

    // control word storage, all 16 bits kept as written
    if (wr.wr) begin
      st_d.cw = wr.data;                                       // [RULE_03]
    end
    st_d.fault_clr = 1'b0;

    if (FAULT_IN && st_q.state != DCWD_FAULT) begin
      st_d.state        = DCWD_FAULT;
      st_d.jog_run      = 1'b0;
      st_d.jog_mode     = 1'b0;
      st_d.jog_stopping = 1'b0;
    end else if (st_q.state == DCWD_FAULT) begin
      if (flt_rst_rise) begin
        st_d.state     = DCWD_SOD;                             // [RULE_11]
        st_d.fault_clr = 1'b1;                                 // [RULE_11]
      end
    end else if (jog_rise) begin
      st_d.state        = DCWD_OPEN;                           // [RULE_01]
      st_d.jog_mode     = 1'b1;                                // [RULE_01]
      st_d.jog_run      = 1'b1;                                // [RULE_01]
      st_d.jog_stopping = 1'b0;
    end else if (jog_fall && st_q.jog_mode) begin
      st_d.jog_run      = 1'b0;                                // [RULE_02]
      st_d.jog_stopping = 1'b1;                                // [RULE_02]
    end else if (st_q.jog_stopping) begin
      if (STANDSTILL) begin
        st_d.state        = DCWD_SOD;                          // [RULE_02]
        st_d.jog_stopping = 1'b0;
        st_d.jog_mode     = 1'b0;
      end
    end else if (wr.wr && !st_q.jog_mode) begin                // [RULE_02]
      // jog owns the state machine until its stop completes
      case (st_q.state)
        DCWD_SOD: begin
          if (cmd == DCWD_CMD_SHUTDOWN) begin
            st_d.state = DCWD_RTSO;                            // [RULE_06]
          end
        end
        DCWD_RTSO: begin
          if (cmd == DCWD_CMD_SWITCHON) begin
            st_d.state = DCWD_SWON;                            // [RULE_07]
          end else if (cmd == DCWD_CMD_DISVOLT || cmd == DCWD_CMD_QSTOP) begin
            st_d.state = DCWD_SOD;                             // [RULE_08] [RULE_09]
          end
        end
        DCWD_SWON: begin
          if (cmd == DCWD_CMD_ENAOP) begin
            st_d.state = DCWD_OPEN;                            // [RULE_10]
          end else if (cmd == DCWD_CMD_SHUTDOWN) begin
            st_d.state = DCWD_RTSO;                            // [RULE_06]
          end else if (cmd == DCWD_CMD_DISVOLT || cmd == DCWD_CMD_QSTOP) begin
            st_d.state = DCWD_SOD;                             // [RULE_08] [RULE_09]
          end
        end
        DCWD_OPEN: begin
          if (cmd == DCWD_CMD_SWITCHON) begin
            st_d.state = DCWD_SWON;                            // [RULE_07]
          end else if (cmd == DCWD_CMD_SHUTDOWN) begin
            st_d.state = DCWD_RTSO;                            // [RULE_06]
          end else if (cmd == DCWD_CMD_DISVOLT) begin
            st_d.state = DCWD_SOD;                             // [RULE_08]
          end else if (cmd == DCWD_CMD_QSTOP) begin
            st_d.state = DCWD_QSA;                             // [RULE_09]
          end
        end
        DCWD_QSA: begin
          if (cmd == DCWD_CMD_DISVOLT) begin
            st_d.state = DCWD_SOD;                             // [RULE_08]
          end else if (cmd == DCWD_CMD_ENAOP) begin
            st_d.state = DCWD_OPEN;                            // [RULE_10]
          end
        end
        default: begin
          st_d.state = st_q.state;                             // [RULE_14]
        end
      endcase
    end

    st_d.power_en  = (st_d.state == DCWD_OPEN) || (st_d.state == DCWD_QSA);
    st_d.qstop_req = (st_d.state == DCWD_QSA);
    st_d.state_num = state_number(st_d.state);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q              <= '0;
      st_q.state        <= DCWD_SOD;
      st_q.cw           <= `DCWD_CW_RESET;
      st_q.state_num    <= `DCWD_NUM_SOD;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign CW_RDATA     = st_q.cw;
  assign STATE_ONEHOT = st_q.state;
  assign STATE_NUM    = st_q.state_num;
  assign POWER_EN     = st_q.power_en;
  assign QSTOP_REQ    = st_q.qstop_req;
  assign HALT_REQ     = st_q.cw[`DCWD_BIT_HALT];               // [RULE_12]
  assign JOG_MODE     = st_q.jog_mode;
  assign JOG_NEG_RUN  = st_q.jog_run;
  assign FAULT_CLR    = st_q.fault_clr;
  assign MODE_BITS    = {st_q.cw[`DCWD_BIT_MODE_9],
                         st_q.cw[`DCWD_BIT_MODE_HI:`DCWD_BIT_MODE_LO]}; // [RULE_13]

endmodule : dcwd_top

// ==== tb/dcwd_checker.sv ====
// concurrent checks on the ports of the control word decoder
`timescale 1ns/1ps
module dcwd_checker
  import dcwd_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        CW_WR,
  input wire logic [15:0] CW_WDATA,
  input wire logic        FAULT_IN,
  input wire logic        STANDSTILL,
  input wire logic [15:0] CW_RDATA,
  input wire logic [3:0]  STATE_NUM,
  input wire logic        POWER_EN,
  input wire logic        QSTOP_REQ,
  input wire logic        HALT_REQ,
  input wire logic        JOG_MODE,
  input wire logic        JOG_NEG_RUN,
  input wire logic        FAULT_CLR,
  input wire logic [3:0]  MODE_BITS
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // write that may act as a level command
  wire free = CW_WR && !FAULT_IN && !JOG_MODE && !CW_WDATA[7] && STATE_NUM != 4'h9;
  wire [3:0] cmd = CW_WDATA[3:0];
  // ---------------------------------------------------------------
  // jog stop sequence
  // ---------------------------------------------------------------
  sequence stop_s;
    JOG_MODE && !JOG_NEG_RUN && STANDSTILL && !FAULT_IN;
  endsequence
  sequence off_s;
    STATE_NUM == 4'h3 && !POWER_EN && !JOG_MODE;
  endsequence
  AST_JOG_RISE: assert property ($rose(JOG_NEG_RUN) |-> POWER_EN && JOG_MODE && STATE_NUM == 4'h6)
    else $error("jog start wrong");
  AST_JOG_STOP: assert property (JOG_MODE && !JOG_NEG_RUN |-> POWER_EN)
    else $error("power off before stop");
  AST_JOG_FALL: assert property (stop_s |=> off_s)
    else $error("jog end wrong");
  AST_CW_NOW: assert property (CW_WR |=> CW_RDATA == $past(CW_WDATA))
    else $error("word not stored");
  AST_HALT: assert property (CW_WR |=> HALT_REQ == $past(CW_WDATA[8]))
    else $error("halt wrong");
  AST_MODE: assert property (CW_WR |=> MODE_BITS == {$past(CW_WDATA[9]), $past(CW_WDATA[6:4])})
    else $error("mode bits wrong");
  AST_SHUT: assert property (free && cmd[2:0] == 3'h6 && STATE_NUM inside {4'h3, 4'h5, 4'h6} |=> STATE_NUM == 4'h4)
    else $error("shutdown wrong");
  AST_SWON: assert property (free && cmd == 4'h7 && STATE_NUM inside {4'h4, 4'h6} |=> STATE_NUM == 4'h5)
    else $error("switch on wrong");
  AST_DISV: assert property (free && !cmd[1] |=> STATE_NUM == 4'h3 && !POWER_EN)
    else $error("disable voltage wrong");
  AST_QST: assert property (free && cmd[2:1] == 2'h1 && STATE_NUM inside {4'h4, 4'h5, 4'h6}
    |=> STATE_NUM == ($past(STATE_NUM) == 4'h6 ? 4'h7 : 4'h3))
    else $error("quick stop wrong");
  AST_ENOP: assert property (free && cmd == 4'hF && STATE_NUM inside {4'h5, 4'h7} |=> STATE_NUM == 4'h6 && POWER_EN)
    else $error("enable operation wrong");
  AST_FRST: assert property (CW_WR && !FAULT_IN && STATE_NUM == 4'h9 && CW_WDATA[7] && !CW_RDATA[7]
    |=> STATE_NUM == 4'h3 && FAULT_CLR)
    else $error("fault reset wrong");
  AST_KEEP: assert property (free && cmd == 4'hF && STATE_NUM == 4'h3 |=> STATE_NUM == 4'h3)
    else $error("invalid pattern moved state");
  AST_QSR: assert property (QSTOP_REQ == (STATE_NUM == 4'h7))
    else $error("quick stop request wrong");
endmodule : dcwd_checker

bind dcwd_top dcwd_checker u_chk (.CORE_CLK, .SYS_RST, .CW_WR, .CW_WDATA, .FAULT_IN, .STANDSTILL,
  .CW_RDATA, .STATE_NUM, .POWER_EN, .QSTOP_REQ, .HALT_REQ, .JOG_MODE, .JOG_NEG_RUN, .FAULT_CLR,
  .MODE_BITS);

// ==== tb/dcwd_master_model.sv ====
// fieldbus master, local pins and motor stand-in
`timescale 1ns/1ps
module dcwd_master_model
  import dcwd_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        JOG_NEG_RUN,
  output logic             CW_WR,
  output logic      [15:0] CW_WDATA,
  output logic             JOG_NEG_ENA_IN,
  output logic             FAULT_IN,
  output logic             STANDSTILL
);
  logic [2:0] idle_q = 3'h4;
  initial begin
    CW_WR = 1'b0;
    CW_WDATA = 16'h0000;
    JOG_NEG_ENA_IN = 1'b0;
    FAULT_IN = 1'b0;
  end
  // motor reports stopped on the fifth falling clock edge after run drops
  always @(negedge CORE_CLK) begin
    idle_q <= JOG_NEG_RUN ? 3'h0 : (idle_q == 3'h4 ? idle_q : idle_q + 3'h1);
    STANDSTILL <= !JOG_NEG_RUN && idle_q == 3'h4;
  end
  task put(input logic [15:0] w);
    @(negedge CORE_CLK);
    CW_WR <= 1'b1;
    CW_WDATA <= w; // callers keep bits 10..15 zero
    @(negedge CORE_CLK);
    CW_WR <= 1'b0;
    CW_WDATA <= ~w;
  endtask : put
  task pin(input logic v);
    @(negedge CORE_CLK);
    JOG_NEG_ENA_IN <= v;
  endtask : pin
  task flt(input logic v);
    @(negedge CORE_CLK);
    FAULT_IN <= v;
  endtask : flt
endmodule : dcwd_master_model

// ==== tb/test_drive_control_word_decoder.sv ====
// self-checking bench of the drive control word decoder
`timescale 1ns/1ps
module test_drive_control_word_decoder
  import dcwd_pkg::*;
;
  logic        clk, rst, wr, jog, fin, sst, pe, qs, hr, jm, jr, fc;
  logic [15:0] wd, rd;
  logic [5:0]  oh;
  logic [3:0]  sn, mb;
  int          checks, miscompares, n;
  dcwd_top dut (.CORE_CLK(clk), .SYS_RST(rst), .CW_WR(wr), .CW_WDATA(wd), .JOG_NEG_ENA_IN(jog),
    .FAULT_IN(fin), .STANDSTILL(sst), .CW_RDATA(rd), .STATE_ONEHOT(oh), .STATE_NUM(sn),
    .POWER_EN(pe), .QSTOP_REQ(qs), .HALT_REQ(hr), .JOG_MODE(jm), .JOG_NEG_RUN(jr),
    .FAULT_CLR(fc), .MODE_BITS(mb));
  dcwd_master_model m (.CORE_CLK(clk), .JOG_NEG_RUN(jr), .CW_WR(wr), .CW_WDATA(wd),
    .JOG_NEG_ENA_IN(jog), .FAULT_IN(fin), .STANDSTILL(sst));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task go(input logic [15:0] w, input logic [3:0] e);
    m.put(w);
    chk(16'(sn), 16'(e));
  endtask : go
  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task t_walk;
    go(16'h0006, 4'h4);
    go(16'h0007, 4'h5);
    go(16'h000F, 4'h6);
    chk(16'(pe), 16'h0001);
    go(16'h0007, 4'h5);
    go(16'h000F, 4'h6);
    go(16'h000B, 4'h7);
    chk(16'(qs), 16'h0001);
    go(16'h000F, 4'h6);
    go(16'h0000, 4'h3);
    $display("walk done");
  endtask : t_walk
  task t_qlo;
    go(16'h0006, 4'h4);
    go(16'h0002, 4'h3);
    go(16'h0006, 4'h4);
    go(16'h0007, 4'h5);
    go(16'h0003, 4'h3);
    go(16'h000F, 4'h3);
    go(16'h0086, 4'h3);
    $display("quick stop done");
  endtask : t_qlo
  task t_word;
    m.put(16'h0370);
    chk(rd, 16'h0370);
    chk(16'({hr, mb}), 16'h001F);
    m.put(16'h0050);
    chk(16'({hr, mb}), 16'h0005);
    $display("word done");
  endtask : t_word
  task t_fault;
    m.flt(1'b1);
    m.flt(1'b0);
    chk(16'(sn), 16'h0009);
    go(16'h0080, 4'h3);
    chk(16'(fc), 16'h0001);
    go(16'h0006, 4'h4);
    $display("fault done");
  endtask : t_fault
  task t_jog;
    m.pin(1'b1);
    for (n = 0; n < 10 && jm !== 1'b1; n++) @(negedge clk);
    chk(16'({sn, pe, jr}), 16'h001B);
    go(16'h0000, 4'h6);
    m.pin(1'b0);
    for (n = 0; n < 10 && jr !== 1'b0; n++) @(negedge clk);
    chk(16'({pe, jm}), 16'h0003);
    for (n = 0; n < 20 && jm !== 1'b0; n++) @(negedge clk);
    chk(16'({sn, pe}), 16'h0006);
    $display("jog done");
  endtask : t_jog
  initial begin
    rst = 1'b1;
    checks = 0;
    miscompares = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({oh, sn, 6'h00}, {6'h01, 4'h3, 6'h00});
    chk(rd, 16'h0000);
    rst = 1'b0;
    t_walk;
    t_qlo;
    t_word;
    t_fault;
    t_jog;
    finish_test;
  end
  initial begin
    #50000;
    miscompares++;
    finish_test;
  end
endmodule : test_drive_control_word_decoder
